// ===== hdl/pwc_defs.vh
// register offsets, field positions, reset values and timing constants
// for the pulse output and wiring configuration block
// assumes a 12-bit register address from the device core
`ifndef PWC_DEFS_VH
`define PWC_DEFS_VH

// register offsets
`define PWC_ADDR_OUT_CFG        12'h490
`define PWC_ADDR_PHASE_MASKS    12'h491
`define PWC_ADDR_ACC_WIRING     12'h492

// reset values
`define PWC_OUT_CFG_RST         16'h0000
`define PWC_PHASE_MASKS_RST     16'h0000
`define PWC_ACC_WIRING_RST      16'h0000

// writable bits, all others read as zero
`define PWC_OUT_CFG_WMASK       16'hffff
`define PWC_PHASE_MASKS_WMASK   16'h0fff
`define PWC_ACC_WIRING_WMASK    16'h01f0

// field positions
`define PWC_TYPE_W              3
`define PWC_MASK_W              3
`define PWC_DIS_LSB             4'hc
`define PWC_LINE_FREQ_BIT       4'h8
`define PWC_DERIVED_IB_BIT      4'h7
`define PWC_WIRING_LSB          4'h4

// energy type codes
`define PWC_TYPE_ACTIVE         3'h0
`define PWC_TYPE_REACTIVE       3'h1
`define PWC_TYPE_APPARENT       3'h2
`define PWC_TYPE_FUND_REACTIVE  3'h4

// wiring codes
`define PWC_WIRE_WYE4           3'h0
`define PWC_WIRE_DELTA3         3'h1
`define PWC_WIRE_WYE4_NB        3'h2
`define PWC_WIRE_DELTA4_NB      3'h3
`define PWC_WIRE_DELTA3_LL      3'h4

// line frequency and derived default line period
`define PWC_CLK_HZ              200000000
`define PWC_LINE_FREQ_LO_HZ     50
`define PWC_LINE_FREQ_HI_HZ     60
// sys_clk cycles per line period: clock rate over 50 Hz and over 60 Hz
`define PWC_PERIOD_LO_CYC       24'h3d0900
`define PWC_PERIOD_HI_CYC       24'h32dcd5

`endif

// ===== hdl/pwc_top.v
// pulse output selection, phase masking, line frequency and wiring
// substitution for a polyphase metering core
// assumes samples and per-phase powers arrive synchronous to sys_clk,
// one valid value per cycle, and a simple strobed register port
`include "pwc_defs.vh"

module pwc_top #(
    parameter DW         = 24,
    parameter PW         = 32,
    parameter AW         = 40,
    parameter [39:0] THR = 40'h0000100000,
    parameter PULSE_LOW  = 16
) (
    input  wire                 sys_clk,
    input  wire                 reset_n,
    input  wire [11:0]          reg_addr,
    input  wire                 reg_wr_en,
    input  wire [15:0]          reg_wdata,
    input  wire                 reg_rd_en,
    output reg  [15:0]          reg_rdata,
    input  wire signed [DW-1:0] phase_a_current,
    input  wire signed [DW-1:0] phase_b_current,
    input  wire signed [DW-1:0] phase_c_current,
    input  wire signed [DW-1:0] phase_a_voltage,
    input  wire signed [DW-1:0] phase_b_voltage,
    input  wire signed [DW-1:0] phase_c_voltage,
    input  wire signed [PW-1:0] act_pwr_a,
    input  wire signed [PW-1:0] act_pwr_b,
    input  wire signed [PW-1:0] act_pwr_c,
    input  wire signed [PW-1:0] react_pwr_a,
    input  wire signed [PW-1:0] react_pwr_b,
    input  wire signed [PW-1:0] react_pwr_c,
    input  wire signed [PW-1:0] appar_pwr_a,
    input  wire signed [PW-1:0] appar_pwr_b,
    input  wire signed [PW-1:0] appar_pwr_c,
    input  wire signed [PW-1:0] fund_react_pwr_a,
    input  wire signed [PW-1:0] fund_react_pwr_b,
    input  wire signed [PW-1:0] fund_react_pwr_c,
    output reg  [DW+1:0]        phase_a_current_out,
    output reg  [DW+1:0]        phase_b_current_out,
    output reg  [DW+1:0]        phase_c_current_out,
    output reg  [DW+1:0]        phase_a_voltage_out,
    output reg  [DW+1:0]        phase_b_voltage_out,
    output reg  [DW+1:0]        phase_c_voltage_out,
    output reg                  line_freq_60hz,
    output reg  [23:0]          default_line_period,
    output reg                  pulse_out1,
    output reg                  pulse_out2,
    output reg                  pulse_out3,
    output reg                  pulse_out4,
    output reg  [3:0]           pulse_event
);

    localparam [23:0] PERIOD_LO = `PWC_PERIOD_LO_CYC;
    localparam [23:0] PERIOD_HI = `PWC_PERIOD_HI_CYC;
    localparam [15:0] PLOW      = PULSE_LOW[15:0];

    // configuration registers
    reg  [15:0]         pulse_output_config_r;
    reg  [15:0]         pulse_phase_masks_r;
    reg  [15:0]         accumulation_and_wiring_config_r;

    // accumulation state per output
    reg  signed [AW-1:0] acc_r   [0:3];
    reg  [15:0]          low_r   [0:3];
    reg  signed [AW-1:0] term    [0:3];
    reg  [3:0]           fire;
    reg  signed [AW-1:0] acc_nxt [0:3];
    integer              k;
    integer              j;

    wire signed [AW-1:0] thr_pos = THR;
    wire signed [AW-1:0] thr_neg = -thr_pos;

    // sign extension of a power value to accumulator width
    function signed [AW-1:0] sext_p;
        input signed [PW-1:0] v;
        begin
            sext_p = {{(AW-PW){v[PW-1]}}, v};
        end
    endfunction

    // sign extension of a sample to output width
    function signed [DW+1:0] sext_s;
        input signed [DW-1:0] v;
        begin
            sext_s = {{2{v[DW-1]}}, v};
        end
    endfunction

    // pick one phase power by energy type code
    function signed [AW-1:0] pick;
        input [2:0]           t;
        input signed [PW-1:0] act;
        input signed [PW-1:0] react;
        input signed [PW-1:0] appar;
        input signed [PW-1:0] fund;
        begin
            case (t)
                `PWC_TYPE_REACTIVE:      pick = sext_p(react);
                `PWC_TYPE_APPARENT:      pick = sext_p(appar);
                `PWC_TYPE_FUND_REACTIVE: pick = sext_p(fund);
                default:                 pick = sext_p(act);
            endcase
        end
    endfunction

    // masked sum of the three phases for one output
    function signed [AW-1:0] masked_sum;
        input [2:0]           m;
        input signed [AW-1:0] pa;
        input signed [AW-1:0] pb;
        input signed [AW-1:0] pc;
        reg signed [AW-1:0]   s;
        begin
            s = {AW{1'b0}};
            if (m[0]) begin
                s = s + pa;
            end
            if (m[1]) begin
                s = s + pb;
            end
            if (m[2]) begin
                s = s + pc;
            end
            masked_sum = s;
        end
    endfunction

    // register writes, reserved bits masked off
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_output_config_r            <= `PWC_OUT_CFG_RST;
            pulse_phase_masks_r              <= `PWC_PHASE_MASKS_RST;
            accumulation_and_wiring_config_r <= `PWC_ACC_WIRING_RST;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `PWC_ADDR_OUT_CFG: begin
                    pulse_output_config_r <= reg_wdata & `PWC_OUT_CFG_WMASK;
                end
                `PWC_ADDR_PHASE_MASKS: begin
                    pulse_phase_masks_r <=
                        reg_wdata & `PWC_PHASE_MASKS_WMASK;
                end
                `PWC_ADDR_ACC_WIRING: begin
                    accumulation_and_wiring_config_r <=
                        reg_wdata & `PWC_ACC_WIRING_WMASK;
                end
                default: begin
                end
            endcase
        end
    end

    // register reads, unmapped addresses return zero
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd_en) begin
            case (reg_addr)
                `PWC_ADDR_OUT_CFG:     reg_rdata <= pulse_output_config_r;
                `PWC_ADDR_PHASE_MASKS: reg_rdata <= pulse_phase_masks_r;
                `PWC_ADDR_ACC_WIRING:
                    reg_rdata <= accumulation_and_wiring_config_r;
                default:               reg_rdata <= 16'h0000;
            endcase
        end
    end

    // per-output term: type selection then phase masking
    always @* begin
        for (k = 0; k < 4; k = k + 1) begin
            term[k] = masked_sum(
                pulse_phase_masks_r[3*k +: 3],
                pick(pulse_output_config_r[3*k +: 3],
                     act_pwr_a, react_pwr_a, appar_pwr_a, fund_react_pwr_a),
                pick(pulse_output_config_r[3*k +: 3],
                     act_pwr_b, react_pwr_b, appar_pwr_b, fund_react_pwr_b),
                pick(pulse_output_config_r[3*k +: 3],
                     act_pwr_c, react_pwr_c, appar_pwr_c, fund_react_pwr_c));
            acc_nxt[k] = acc_r[k] + term[k];
            fire[k] = (acc_nxt[k] >= thr_pos) || (acc_nxt[k] <= thr_neg);
        end
    end

    // pin level: high while disabled, low while firing or while the count is above one
    function pin_level;
        input        dis;
        input        f;
        input [15:0] cnt;
        begin
            pin_level = dis | ~(f | (cnt > 16'h0001));
        end
    endfunction

    // energy-to-frequency accumulation and pulse shaping
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (j = 0; j < 4; j = j + 1) begin
                acc_r[j] <= {AW{1'b0}};
                low_r[j] <= 16'h0000;
            end
            pulse_out1  <= 1'b1;
            pulse_out2  <= 1'b1;
            pulse_out3  <= 1'b1;
            pulse_out4  <= 1'b1;
            pulse_event <= 4'h0;
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (acc_nxt[j] >= thr_pos) begin
                    acc_r[j] <= acc_nxt[j] - thr_pos;
                end else if (acc_nxt[j] <= thr_neg) begin
                    acc_r[j] <= acc_nxt[j] + thr_pos;
                end else begin
                    acc_r[j] <= acc_nxt[j];
                end
                // no pulse kept while disabled: no stub pulse on re-enable
                if (pulse_output_config_r[`PWC_DIS_LSB + j]) begin
                    low_r[j] <= 16'h0000;
                end else if (fire[j]) begin
                    low_r[j] <= PLOW;
                end else if (low_r[j] != 16'h0000) begin
                    low_r[j] <= low_r[j] - 16'h0001;
                end
                pulse_event[j] <= fire[j] &
                    ~pulse_output_config_r[`PWC_DIS_LSB + j];
            end
            // disabled pin held high
            pulse_out1 <= pin_level(pulse_output_config_r[`PWC_DIS_LSB],
                                    fire[0], low_r[0]);
            pulse_out2 <= pin_level(pulse_output_config_r[`PWC_DIS_LSB + 1],
                                    fire[1], low_r[1]);
            pulse_out3 <= pin_level(pulse_output_config_r[`PWC_DIS_LSB + 2],
                                    fire[2], low_r[2]);
            pulse_out4 <= pin_level(pulse_output_config_r[`PWC_DIS_LSB + 3],
                                    fire[3], low_r[3]);
        end
    end

    // substituted sample values, registered
    wire [2:0] wiring = accumulation_and_wiring_config_r[6:4];
    wire signed [DW+1:0] va = sext_s(phase_a_voltage);
    wire signed [DW+1:0] vb = sext_s(phase_b_voltage);
    wire signed [DW+1:0] vc = sext_s(phase_c_voltage);
    wire signed [DW+1:0] ia = sext_s(phase_a_current);
    wire signed [DW+1:0] ib = sext_s(phase_b_current);
    wire signed [DW+1:0] ic = sext_s(phase_c_current);

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_a_current_out <= {(DW+2){1'b0}};
            phase_b_current_out <= {(DW+2){1'b0}};
            phase_c_current_out <= {(DW+2){1'b0}};
            phase_a_voltage_out <= {(DW+2){1'b0}};
            phase_b_voltage_out <= {(DW+2){1'b0}};
            phase_c_voltage_out <= {(DW+2){1'b0}};
            line_freq_60hz      <= 1'b0;
            default_line_period <= 24'h000000;
        end else begin
            phase_a_current_out <= ia;
            phase_c_current_out <= ic;
            if (accumulation_and_wiring_config_r[`PWC_DERIVED_IB_BIT]) begin
                phase_b_current_out <= -ia - ic;
            end else begin
                phase_b_current_out <= ib;
            end
            phase_a_voltage_out <= va;
            phase_b_voltage_out <= vb;
            phase_c_voltage_out <= vc;
            case (wiring)
                `PWC_WIRE_DELTA3:    phase_b_voltage_out <= va - vc;
                `PWC_WIRE_WYE4_NB:   phase_b_voltage_out <= -va - vc;
                `PWC_WIRE_DELTA4_NB: phase_b_voltage_out <= -va;
                `PWC_WIRE_DELTA3_LL: begin
                    phase_a_voltage_out <= va - vb;
                    phase_b_voltage_out <= va - vc;
                    phase_c_voltage_out <= vc - vb;
                end
                default: begin
                end
            endcase
            line_freq_60hz <=
                accumulation_and_wiring_config_r[`PWC_LINE_FREQ_BIT];
            default_line_period <=
                accumulation_and_wiring_config_r[`PWC_LINE_FREQ_BIT] ?
                PERIOD_HI : PERIOD_LO;
        end
    end

endmodule

// ===== verif/pwc_assertions.sv
// concurrent checks on the register port, first pulse pin and sample path of pwc_top
// bound into every pwc_top; sees its ports only
`include "pwc_defs.vh"
module pwc_chk #(
    parameter DW        = 24,
    parameter PULSE_LOW = 16
) (
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    input wire logic [11:0]          reg_addr,
    input wire logic                 reg_wr_en,
    input wire logic [15:0]          reg_wdata,
    input wire logic                 reg_rd_en,
    input wire logic [15:0]          reg_rdata,
    input wire logic signed [DW-1:0] phase_a_current,
    input wire logic [DW+1:0]        phase_a_current_out,
    input wire logic                 line_freq_60hz,
    input wire logic [23:0]          default_line_period,
    input wire logic                 pulse_out1,
    input wire logic [3:0]           pulse_event
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] low_cnt_r;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // consecutive low cycles of the first pin
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            low_cnt_r <= 16'h0000;
        else if (pulse_out1)
            low_cnt_r <= 16'h0000;
        else if (low_cnt_r != 16'hffff)
            low_cnt_r <= low_cnt_r + 16'h0001;
    end
    // write then read of the wiring register
    sequence s_wr_acc;
        reg_wr_en && reg_addr == `PWC_ADDR_ACC_WIRING && !reg_rd_en;
    endsequence
    sequence s_rd_acc;
        reg_rd_en && reg_addr == `PWC_ADDR_ACC_WIRING && !reg_wr_en;
    endsequence
    a_unmapped_reads_zero: assert property (
        reg_rd_en && reg_addr > 12'h492 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_acc_read_back: assert property (s_wr_acc ##1 s_rd_acc
        |=> reg_rdata == ($past(reg_wdata, 2) & 16'h01f0))
        else $error("wiring register read back wrong");
    a_freq_follows_wr: assert property (s_wr_acc
        |-> ##2 line_freq_60hz == $past(reg_wdata[8], 2))
        else $error("line frequency bit not applied");
    a_period_matches: assert property ($past(reset_n) |->
        default_line_period == (line_freq_60hz ? `PWC_PERIOD_HI_CYC :
                                `PWC_PERIOD_LO_CYC))
        else $error("default line period wrong");
    a_fire_pin_low: assert property (pulse_event[0] |-> !pulse_out1)
        else $error("event without low pin");
    a_pin_falls_fire: assert property (
        $fell(pulse_out1) |-> pulse_event[0])
        else $error("pin fell without event");
    a_pulse_low_width: assert property (
        $rose(pulse_out1) && $past(reset_n) |-> low_cnt_r >= PULSE_LOW)
        else $error("pin low too short");
    a_ia_passes: assert property ($past(reset_n)
        |-> $signed(phase_a_current_out) == $past(phase_a_current))
        else $error("phase a current altered");
endmodule
bind pwc_top pwc_chk #(.DW(DW), .PULSE_LOW(PULSE_LOW)) i_pwc_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .phase_a_current(phase_a_current),
    .phase_a_current_out(phase_a_current_out),
    .line_freq_60hz(line_freq_60hz),
    .default_line_period(default_line_period), .pulse_out1(pulse_out1),
    .pulse_event(pulse_event));

// ===== verif/tb_pwc_top.sv
// self-checking bench for pwc_top through its strobed register port
// assumes pwc_defs.vh on the include path, sys_clk at 200 MHz
`include "pwc_defs.vh"
module tb_pwc_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [39:0] THR   = 40'h100;
    localparam logic [15:0] WM[4] = '{16'hffff, 16'h0fff, 16'h01f0, 16'h0};
    localparam int          EA[6] = '{100, 100, 100, 100, 70, 100};
    localparam int          EB[6] = '{30, 93, -107, -100, 93, 30};
    localparam int          EC[6] = '{7, 7, 7, 7, -23, 7};
    localparam int          PM[3] = '{2, 1, 4};
    logic               sys_clk, reset_n, wr_en, rd_en;
    logic [11:0]        addr;
    logic [15:0]        wdata;
    logic signed [23:0] smp[6];
    logic signed [31:0] pw[12];
    wire [15:0]         rdata;
    wire [25:0]         so[6];
    wire [23:0]         per;
    wire [3:0]          pin, ev;
    wire                lf;
    int                 n_mismatch, num_checks;
    // free running clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    pwc_top #(.THR(THR), .PULSE_LOW(4)) i_pwc_top (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en),
        .reg_rdata(rdata), .phase_a_current(smp[0]),
        .phase_b_current(smp[1]), .phase_c_current(smp[2]),
        .phase_a_voltage(smp[3]), .phase_b_voltage(smp[4]),
        .phase_c_voltage(smp[5]), .act_pwr_a(pw[0]), .act_pwr_b(pw[1]),
        .act_pwr_c(pw[2]), .react_pwr_a(pw[3]), .react_pwr_b(pw[4]),
        .react_pwr_c(pw[5]), .appar_pwr_a(pw[6]), .appar_pwr_b(pw[7]),
        .appar_pwr_c(pw[8]), .fund_react_pwr_a(pw[9]),
        .fund_react_pwr_b(pw[10]), .fund_react_pwr_c(pw[11]),
        .phase_a_current_out(so[0]), .phase_b_current_out(so[1]),
        .phase_c_current_out(so[2]), .phase_a_voltage_out(so[3]),
        .phase_b_voltage_out(so[4]), .phase_c_voltage_out(so[5]),
        .line_freq_60hz(lf), .default_line_period(per),
        .pulse_out1(pin[0]), .pulse_out2(pin[1]), .pulse_out3(pin[2]),
        .pulse_out4(pin[3]), .pulse_event(ev));
    // 26-bit sample value, zero padded
    function automatic logic [39:0] e26(input int v);
        return {14'h0, 26'(v)};
    endfunction
    task automatic chk(input string name, input logic [39:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk("reg_rdata", 40'(rdata), 40'(e));
    endtask
    // write, then read back on the very next edge
    task automatic wr_rd(input logic [11:0] a, input logic [15:0] d, e);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk("reg_rdata", 40'(rdata), 40'(e));
    endtask
    // one power input at threshold, k below zero for none
    task automatic pwr(input int k);
        @(posedge sys_clk);
        foreach (pw[i]) pw[i] <= (i == k) ? THR[31:0] : 32'h0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        {reset_n, wr_en, rd_en, addr, wdata} = '0;
        smp = '{24'sd5, 24'sd30, 24'sd3, 24'sd100, 24'sd30, 24'sd7};
        foreach (pw[i]) pw[i] = 32'sh0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`PWC_ADDR_OUT_CFG, 16'h0000);
        rd(`PWC_ADDR_PHASE_MASKS, 16'h0000);
        rd(`PWC_ADDR_ACC_WIRING, 16'h0000);
        chk("period", 40'(per), 40'd4000000);
        chk("pins", 40'(pin), 40'hf);
        for (int i = 0; i < 4; i++)
            wr_rd(12'h490 + 12'(i), 16'hffff, WM[i]);
        wr_rd(`PWC_ADDR_ACC_WIRING, 16'h0180, 16'h0180);
        repeat (2) @(posedge sys_clk);
        chk("line_freq", 40'(lf), 40'h1);
        chk("period", 40'(per), 40'd3333333);
        chk("ib_out", 40'(so[1]), e26(-8));
        chk("ia_out", 40'(so[0]), e26(5));
        chk("ic_out", 40'(so[2]), e26(3));
        for (int c = 0; c < 6; c++) begin
            wr_rd(`PWC_ADDR_ACC_WIRING, 16'(c << 4), 16'(c << 4));
            chk("va_out", 40'(so[3]), e26(EA[c]));
            chk("vb_out", 40'(so[4]), e26(EB[c]));
            chk("vc_out", 40'(so[5]), e26(EC[c]));
        end
        chk("ib_out", 40'(so[1]), e26(30));
        wr_rd(`PWC_ADDR_PHASE_MASKS, 16'h0249, 16'h0249);
        wr_rd(`PWC_ADDR_OUT_CFG, 16'h0888, 16'h0888);
        for (int k = 0; k < 4; k++) begin
            pwr(k * 3);
            chk("event", 40'(ev), 40'(1 << k));
            chk("pins", 40'(pin), 40'hf ^ 40'(1 << k));
        end
        for (int c = 0; c < 8; c++) begin
            wr_rd(`PWC_ADDR_OUT_CFG, 16'(c << 9) | 16'h49,
                  16'(c << 9) | 16'h49);
            pwr(0);
            chk("event", 40'(ev), (c == 1 || c == 2 || c == 4) ? 0 : 8);
        end
        wr_rd(`PWC_ADDR_OUT_CFG, 16'h0000, 16'h0000);
        wr_rd(`PWC_ADDR_PHASE_MASKS, 16'h010a, 16'h010a);
        for (int p = 0; p < 3; p++) begin
            pwr(p);
            chk("event", 40'(ev), 40'(PM[p]));
        end
        wr_rd(`PWC_ADDR_PHASE_MASKS, 16'h0249, 16'h0249);
        wr_rd(`PWC_ADDR_OUT_CFG, 16'h1000, 16'h1000);
        pwr(0);
        chk("event", 40'(ev), 40'he);
        chk("pins", 40'(pin), 40'h1);
        pwr(-1);
        repeat (4) @(posedge sys_clk);
        chk("pins", 40'(pin), 40'hf);
        complete_run;
    end
endmodule
